// ===== rtl/sts_pkg.sv
// Package: sources, states, limits and timing for the trigger sequencer
package sts_pkg;
	localparam int COUNT_W = 24;
	localparam logic [23:0] COUNT_MAX_STREAM = 24'hFF_FFFF;   // 16,777,215
	localparam logic [23:0] MEM_TOTAL        = 24'h08_0000;   // 524,288
	localparam logic [23:0] BATT_RESERVE     = 24'h00_0004;
	localparam logic [23:0] COUNT_MIN        = 24'h00_0001;
	localparam logic [23:0] COUNT_SHORT      = 24'h00_0007;
	localparam logic [23:0] COUNT_ROUND_MID  = 24'h00_0004;   // 4..6 round up to 7
	localparam logic [7:0]  SEG_MAX          = 8'h80;         // 128 segments
	localparam logic [23:0] COUNT_RESET      = 24'h00_0001;
	localparam int          PERIOD_W         = 32;
	localparam logic [31:0] PERIOD1_RESET    = 32'h0000_0001;
	localparam logic [31:0] PERIOD2_RESET    = 32'h0000_0002;
	// Extra pre-arm pacing pulse delay: 3 reference periods plus 60 ns
	localparam int REF_PERIODS_GUARD = 3;
	localparam int GUARD_NS          = 60;
	localparam int CLK_NS            = 5;
	localparam int GUARD_CYCLES      = (GUARD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [15:0] ERR_TRIG_IGNORED  = 16'hFF2D;  // -211
	localparam logic [15:0] ERR_TRIG_DEADLOCK = 16'hFF2A;  // -214

	typedef enum logic [3:0] {
		STS_SRC_BUS   = 4'h0,
		STS_SRC_HOLD  = 4'h1,
		STS_SRC_DECL  = 4'h2,
		STS_SRC_DFRNT = 4'h3,
		STS_SRC_DTIM  = 4'h4,
		STS_SRC_ECL0  = 4'h5,
		STS_SRC_ECL1  = 4'h6,
		STS_SRC_IMM   = 4'h7,
		STS_SRC_FRA   = 4'h8,
		STS_SRC_FRB   = 4'h9,
		STS_SRC_TIM   = 4'hA,
		STS_SRC_TTL   = 4'hB,
		STS_SRC_DTTL  = 4'hC,
		STS_SRC_VME   = 4'hD
	} sts_src_t;

	typedef enum logic [1:0] {
		STS_DEST_MEM    = 2'h0,
		STS_DEST_VME    = 2'h1,
		STS_DEST_LOCAL  = 2'h2
	} sts_dest_t;

	typedef enum logic [1:0] {
		STS_IDLE     = 2'h0,
		STS_INIT     = 2'h1,
		STS_WAIT_ARM = 2'h2,
		STS_WAIT_TRG = 2'h3
	} sts_state_t;

	// Configuration written while idle
	typedef struct packed {
		sts_src_t          src;
		logic [2:0]        ttl_sel;
		logic [23:0]       count;
		logic              count_inf;
		logic [7:0]        arm_count;
		logic              pre_arm_neg;
		logic [23:0]       pre_arm_points;
		logic              battery_mode;
		sts_dest_t         dest;
		logic [31:0]       period1;
		logic [31:0]       period2;
	} sts_cfg_t;

	// Raw pacing lines as they arrive at the pins
	typedef struct packed {
		logic       ecl0;
		logic       ecl1;
		logic [7:0] ttl;
		logic       front_a;
		logic       front_b;
		logic       vme_access;
	} sts_lines_t;
endpackage

// ===== rtl/sts_edge_sync.sv
// Two-stage synchroniser with edge detector for one pacing line
`timescale 1ns/1ps
`default_nettype none
module sts_edge_sync (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Line
	input  wire logic line_in,
	output var  logic rise,
	output var  logic fall
);
	logic meta;
	logic sync;
	logic prev;

	// Meta stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end
		else
		begin
			meta <= line_in;
			sync <= meta;
			prev <= sync;
		end
	end

	// Edges from the settled copy only
	assign rise = sync & ~prev;
	assign fall = ~sync & prev;
endmodule // sts_edge_sync
`default_nettype wire

// ===== rtl/sts_period_timer.sv
// Sample period divider producing one-cycle pacing enables
`timescale 1ns/1ps
`default_nettype none
module sts_period_timer #(
	parameter int PERIOD_W = 32
) (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	// Control
	input  wire logic                run,
	input  wire logic [PERIOD_W-1:0] period,
	output var  logic                tick
);
	logic [PERIOD_W-1:0] count;
	logic                wrap;

	// Period is in clock cycles; zero behaves like one
	assign wrap = (count + {{(PERIOD_W-1){1'b0}}, 1'b1}) >= period;
	assign tick = run & wrap;

	// Restart on every stop so a new run gets a full first period
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			count <= '0;
		else if (!run || wrap)
			count <= '0;
		else
			count <= count + {{(PERIOD_W-1){1'b0}}, 1'b1};
	end
endmodule // sts_period_timer
`default_nettype wire

// ===== rtl/sts_sequencer.sv
// Trigger sequencer: arm cycle states, pacing source select, count limits
//Contract
// - Idle, initiated, wait-arm, wait-trigger state sequence
// - One reading per trigger until count met
// - Count and sweep points share one value
// - Streaming to buses allows 16,777,215 readings
// - Post-arm memory cap 524,288 over bursts
// - Battery mode lowers every maximum by four
// - Negative offset, several bursts: segment memory
// - Segments power-of-two bursts, up to 128
// - Counts 1 to 7 round to nearer
// - Infinite count: measure-and-read rejected, -214
// - Count completes before burst total checked
// - Forced trigger in wait-trigger takes reading
// - Forced trigger idle or wait-arm: -211
// - All listed trigger sources offered
// - Dual ECL: line zero pre, one post
// - Dual front: input a pre, b post
// - Dual timer: first period pre, second post
// - Hold source: only forced trigger samples
// - Timer source paces at first period
// - Bus access source triggers or delivers data
// - ECL sources fire on rising edge
// - TTL and front sources fire falling edge
// - No sample on that extra pulse
`timescale 1ns/1ps
`default_nettype none
module sts_sequencer #(
	parameter int COUNT_W  = sts_pkg::COUNT_W,
	parameter int PERIOD_W = sts_pkg::PERIOD_W
) (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	// Configuration strobes and data
	input  wire logic                 cfg_write,
	input  wire logic                 sweep_write,
	input  wire sts_pkg::sts_cfg_t    cfg_in,
	// Commands
	input  wire logic                 initiate_cmd,
	input  wire logic                 abort_cmd,
	input  wire logic                 arm_event,
	input  wire logic                 forced_trigger_cmd,
	input  wire logic                 bus_trigger_cmd,
	input  wire logic                 measure_read_query,
	// Pacing pins
	input  wire sts_pkg::sts_lines_t  lines,
	// Status
	output var  sts_pkg::sts_state_t  state,
	output var  logic [COUNT_W-1:0]   sweep_point_total,
	output var  logic [COUNT_W-1:0]   count_limit,
	output var  logic [7:0]           segment_count,
	output var  logic                 segmented,
	output var  logic [7:0]           burst_index,
	output var  logic                 post_arm,
	// Readings and errors
	output var  logic                 sample_take,
	output var  logic                 vme_data_read,
	output var  logic                 err_valid,
	output var  logic [15:0]          err_code
);
	sts_pkg::sts_cfg_t   cfg;
	sts_pkg::sts_state_t next_state;
	logic [COUNT_W-1:0]  taken;
	logic [7:0]          bursts_done;
	logic                guard_pending;
	logic [7:0]          guard_cnt;

	// Segment count: bursts rounded up to a power of two
	function automatic logic [7:0] seg_round(input logic [7:0] bursts);
		logic [7:0] s;
		s = 8'h01;
		for (int i = 0; i < 7; i++)
			if (s < bursts)
				s = {s[6:0], 1'b0};
		return s;
	endfunction

	// Round counts 1..7 to the nearer of 1 or 7
	function automatic logic [COUNT_W-1:0] round_count(input logic [COUNT_W-1:0] c);
		logic [COUNT_W-1:0] r;
		r = c;
		if (c < sts_pkg::COUNT_MIN)
			r = sts_pkg::COUNT_MIN;
		else if (c < sts_pkg::COUNT_ROUND_MID)
			r = sts_pkg::COUNT_MIN;
		else if (c < sts_pkg::COUNT_SHORT)
			r = sts_pkg::COUNT_SHORT;
		return r;
	endfunction

	// Limit and segmentation decode
	logic [7:0]         seg_n;
	logic [7:0]         bursts_eff;
	logic [COUNT_W-1:0] mem_share;
	logic [COUNT_W-1:0] base_limit;
	logic [COUNT_W-1:0] lim_mem;
	logic               in_idle;
	logic               seg_mode;
	assign in_idle    = (state == sts_pkg::STS_IDLE);
	assign bursts_eff = (cfg_in.arm_count == 8'h00) ? 8'h01 : cfg_in.arm_count;
	assign seg_mode   = (bursts_eff > 8'h01) && cfg_in.pre_arm_neg;
	assign seg_n      = (seg_round(bursts_eff) > sts_pkg::SEG_MAX) ? sts_pkg::SEG_MAX
	                  : seg_round(bursts_eff);
	assign mem_share  = cfg_in.pre_arm_neg ? (sts_pkg::MEM_TOTAL / COUNT_W'(seg_n))
	                  : (sts_pkg::MEM_TOTAL / COUNT_W'(bursts_eff));
	assign lim_mem    = cfg_in.battery_mode ? (mem_share - sts_pkg::BATT_RESERVE) : mem_share;
	assign base_limit = (cfg_in.dest == sts_pkg::STS_DEST_MEM) ? lim_mem
	                  : (cfg_in.battery_mode ? (sts_pkg::COUNT_MAX_STREAM - sts_pkg::BATT_RESERVE)
	                  : sts_pkg::COUNT_MAX_STREAM);

	// Requested count clipped to limit, then short-count rounding
	logic [COUNT_W-1:0] req_clip;
	logic [COUNT_W-1:0] req_final;
	assign req_clip  = (cfg_in.count > base_limit) ? base_limit : cfg_in.count;
	assign req_final = round_count(req_clip);

	// Settings load only while idle; both strobes write one shared count
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg         <= '0;
			cfg.src     <= sts_pkg::STS_SRC_TIM;
			cfg.count   <= sts_pkg::COUNT_RESET;
			cfg.arm_count <= 8'h01;
			cfg.period1 <= sts_pkg::PERIOD1_RESET;
			cfg.period2 <= sts_pkg::PERIOD2_RESET;
			count_limit <= sts_pkg::MEM_TOTAL;
			segment_count <= 8'h01;
			segmented   <= 1'b0;
		end
		else if (in_idle && (cfg_write || sweep_write))
		begin
			cfg           <= cfg_in;
			cfg.arm_count <= bursts_eff;
			cfg.count     <= req_final;
			count_limit   <= base_limit;
			segment_count <= seg_mode ? seg_n : 8'h01;
			segmented     <= seg_mode;
		end
	end
	assign sweep_point_total = cfg.count;

	// Synchronised pacing edges
	logic ecl0_rise;
	logic ecl1_rise;
	logic fa_fall;
	logic fb_fall;
	logic vme_rise;
	logic [7:0] ttl_fall;
	sts_edge_sync u_ecl0 (.clk_sys(clk_sys), .rst_n(rst_n), .line_in(lines.ecl0),
		.rise(ecl0_rise), .fall());
	sts_edge_sync u_ecl1 (.clk_sys(clk_sys), .rst_n(rst_n), .line_in(lines.ecl1),
		.rise(ecl1_rise), .fall());
	sts_edge_sync u_fra (.clk_sys(clk_sys), .rst_n(rst_n), .line_in(lines.front_a),
		.rise(), .fall(fa_fall));
	sts_edge_sync u_frb (.clk_sys(clk_sys), .rst_n(rst_n), .line_in(lines.front_b),
		.rise(), .fall(fb_fall));
	sts_edge_sync u_vme (.clk_sys(clk_sys), .rst_n(rst_n), .line_in(lines.vme_access),
		.rise(vme_rise), .fall());
	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_ttl
			sts_edge_sync u_ttl (.clk_sys(clk_sys), .rst_n(rst_n), .line_in(lines.ttl[g]),
				.rise(), .fall(ttl_fall[g]));
		end
	endgenerate

	// Internal period timers run only while waiting for triggers
	logic tim1_tick;
	logic tim2_tick;
	logic waiting;
	logic dual_tim;
	assign waiting  = (state == sts_pkg::STS_WAIT_TRG);
	assign dual_tim = (cfg.src == sts_pkg::STS_SRC_DTIM);
	sts_period_timer #(.PERIOD_W(PERIOD_W)) u_tim1 (.clk_sys(clk_sys), .rst_n(rst_n),
		.run(waiting && !post_arm), .period(cfg.period1), .tick(tim1_tick));
	sts_period_timer #(.PERIOD_W(PERIOD_W)) u_tim2 (.clk_sys(clk_sys), .rst_n(rst_n),
		.run(waiting && post_arm && dual_tim), .period(cfg.period2), .tick(tim2_tick));

	// Dual-rate pacing pairs
	logic dual_pre;
	logic dual_post;
	logic dual_mode;
	assign dual_mode = (cfg.src == sts_pkg::STS_SRC_DECL) || (cfg.src == sts_pkg::STS_SRC_DFRNT)
	                || dual_tim || (cfg.src == sts_pkg::STS_SRC_DTTL);
	always_comb
	begin
		dual_pre  = 1'b0;
		dual_post = 1'b0;
		unique case (cfg.src)
			sts_pkg::STS_SRC_DECL:
			begin
				dual_pre  = ecl0_rise;
				dual_post = ecl1_rise;
			end
			sts_pkg::STS_SRC_DFRNT:
			begin
				dual_pre  = fa_fall;
				dual_post = fb_fall;
			end
			sts_pkg::STS_SRC_DTIM:
			begin
				dual_pre  = tim1_tick;
				dual_post = tim2_tick;
			end
			sts_pkg::STS_SRC_DTTL:
			begin
				dual_pre  = ttl_fall[0];
				dual_post = ttl_fall[1];
			end
			default:
			begin
				dual_pre  = 1'b0;
				dual_post = 1'b0;
			end
		endcase
	end

	// Single-rate source select
	logic single_evt;
	always_comb
	begin
		single_evt = 1'b0;
		unique case (cfg.src)
			sts_pkg::STS_SRC_BUS:  single_evt = bus_trigger_cmd;
			sts_pkg::STS_SRC_HOLD: single_evt = 1'b0;
			sts_pkg::STS_SRC_ECL0: single_evt = ecl0_rise;
			sts_pkg::STS_SRC_ECL1: single_evt = ecl1_rise;
			sts_pkg::STS_SRC_IMM:  single_evt = 1'b1;
			sts_pkg::STS_SRC_FRA:  single_evt = fa_fall;
			sts_pkg::STS_SRC_FRB:  single_evt = fb_fall;
			sts_pkg::STS_SRC_TIM:  single_evt = tim1_tick;
			sts_pkg::STS_SRC_TTL:  single_evt = ttl_fall[cfg.ttl_sel];
			sts_pkg::STS_SRC_VME:  single_evt = vme_rise;
			default:               single_evt = 1'b0;
		endcase
	end

	// Pre-arm phase ends once arm accepted and the guard pulse seen
	logic arm_in_trg;
	logic guard_done;
	logic guard_pulse;
	assign arm_in_trg  = waiting && dual_mode && !post_arm && !guard_pending && arm_event;
	assign guard_done  = (guard_cnt >= 8'(sts_pkg::GUARD_CYCLES + sts_pkg::REF_PERIODS_GUARD));
	assign guard_pulse = guard_pending && guard_done && dual_pre;

	// Trigger event: forced trigger overrides any source
	logic trig_evt;
	logic last_reading;
	logic bursts_met;
	assign trig_evt = waiting && (forced_trigger_cmd
	                || (dual_mode ? ((!post_arm && !guard_pending && dual_pre)
	                                 || (post_arm && dual_post))
	                              : single_evt));
	assign last_reading = !cfg.count_inf && ((taken + COUNT_W'(1)) >= cfg.count);
	assign bursts_met   = (bursts_done + 8'h01) >= cfg.arm_count;

	// Four-state sequencer
	always_comb
	begin
		next_state = state;
		unique case (state)
			sts_pkg::STS_IDLE:
				if (initiate_cmd)
					next_state = sts_pkg::STS_INIT;
			sts_pkg::STS_INIT:
				next_state = sts_pkg::STS_WAIT_ARM;
			sts_pkg::STS_WAIT_ARM:
				if (arm_event || dual_mode)
					next_state = sts_pkg::STS_WAIT_TRG;
			sts_pkg::STS_WAIT_TRG:
				if (trig_evt && last_reading)
					next_state = bursts_met ? sts_pkg::STS_IDLE : sts_pkg::STS_INIT;
		endcase
		if (abort_cmd)
			next_state = sts_pkg::STS_IDLE;
	end

	// State, reading counters and dual-rate phase
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state         <= sts_pkg::STS_IDLE;
			taken         <= '0;
			bursts_done   <= 8'h00;
			post_arm      <= 1'b0;
			guard_pending <= 1'b0;
			guard_cnt     <= 8'h00;
		end
		else
		begin
			state <= next_state;
			if (state == sts_pkg::STS_IDLE || abort_cmd)
				bursts_done <= 8'h00;
			else if (trig_evt && last_reading && !bursts_met)
				bursts_done <= bursts_done + 8'h01;
			if (state != sts_pkg::STS_WAIT_TRG || abort_cmd)
			begin
				taken         <= '0;
				post_arm      <= 1'b0;
				guard_pending <= 1'b0;
				guard_cnt     <= 8'h00;
			end
			else
			begin
				if (trig_evt)
					taken <= taken + COUNT_W'(1);
				if (arm_in_trg)
					guard_pending <= 1'b1;
				if (guard_pending && !guard_done)
					guard_cnt <= guard_cnt + 8'h01;
				if (guard_pulse)
				begin
					guard_pending <= 1'b0;
					post_arm      <= 1'b1;
				end
			end
		end
	end

	// Segment pointer advances per burst
	assign burst_index = segmented ? bursts_done : 8'h00;

	// Reading strobe, bus-access data delivery, error reports
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sample_take   <= 1'b0;
			vme_data_read <= 1'b0;
			err_valid     <= 1'b0;
			err_code      <= 16'h0000;
		end
		else
		begin
			sample_take   <= trig_evt;
			vme_data_read <= (cfg.src == sts_pkg::STS_SRC_VME) && vme_rise && !waiting;
			err_valid     <= 1'b0;
			if (forced_trigger_cmd && (state == sts_pkg::STS_IDLE
			    || state == sts_pkg::STS_WAIT_ARM))
			begin
				err_valid <= 1'b1;
				err_code  <= sts_pkg::ERR_TRIG_IGNORED;
			end
			else if (measure_read_query && cfg.count_inf)
			begin
				err_valid <= 1'b1;
				err_code  <= sts_pkg::ERR_TRIG_DEADLOCK;
			end
		end
	end
endmodule // sts_sequencer
`default_nettype wire

// ===== dv/sts_sva.sv
// Concurrent checks on the trigger sequencer ports
`timescale 1ns/1ps
`default_nettype none
module sts_sva #(
	parameter int COUNT_W = sts_pkg::COUNT_W
) (
	// Clock and reset
	input wire logic                clk_sys,
	input wire logic                rst_n,
	// Configuration and commands
	input wire logic                cfg_write,
	input wire logic                sweep_write,
	input wire sts_pkg::sts_cfg_t   cfg_in,
	input wire logic                initiate_cmd,
	input wire logic                abort_cmd,
	input wire logic                forced_trigger_cmd,
	// Status and readings
	input wire sts_pkg::sts_state_t state,
	input wire logic [COUNT_W-1:0]  sweep_point_total,
	input wire logic                sample_take,
	input wire logic                err_valid,
	input wire logic [15:0]         err_code
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Either write strobe, accepted or not
	logic wr_any;
	assign wr_any = cfg_write || sweep_write;
	// Start of an arm cycle and its first two steps
	sequence s_start;
		state == sts_pkg::STS_IDLE && initiate_cmd && !abort_cmd;
	endsequence
	sequence s_enter;
		state == sts_pkg::STS_INIT ##1 state inside {sts_pkg::STS_WAIT_ARM, sts_pkg::STS_WAIT_TRG};
	endsequence
	chk_init_steps: assert property (s_start |=> s_enter)
		else $error("initiate did not pass through initiated");
	chk_idle_stays: assert property (state == sts_pkg::STS_IDLE && !initiate_cmd |=> state == sts_pkg::STS_IDLE)
		else $error("idle left without initiate");
	chk_abort_idle: assert property (abort_cmd |=> state == sts_pkg::STS_IDLE)
		else $error("abort did not return to idle");
	chk_sample_state: assert property (sample_take |-> $past(state) == sts_pkg::STS_WAIT_TRG)
		else $error("reading outside wait for trigger");
	chk_forced_take: assert property (forced_trigger_cmd && state == sts_pkg::STS_WAIT_TRG |=> sample_take)
		else $error("forced trigger took no reading");
	chk_forced_refused: assert property (forced_trigger_cmd && state inside {sts_pkg::STS_IDLE, sts_pkg::STS_WAIT_ARM}
		|=> err_valid && err_code == sts_pkg::ERR_TRIG_IGNORED && !sample_take)
		else $error("forced trigger not refused");
	chk_round_low: assert property (state == sts_pkg::STS_IDLE && wr_any && !cfg_in.count_inf
		&& cfg_in.count inside {[2:3]} |=> sweep_point_total == sts_pkg::COUNT_MIN)
		else $error("count 2 or 3 not rounded down");
	chk_round_high: assert property (state == sts_pkg::STS_IDLE && wr_any && !cfg_in.count_inf
		&& cfg_in.count inside {[4:6]} |=> sweep_point_total == sts_pkg::COUNT_SHORT)
		else $error("count 4 to 6 not rounded up");
	chk_busy_frozen: assert property (state != sts_pkg::STS_IDLE && wr_any |=> $stable(sweep_point_total))
		else $error("count changed while busy");
endmodule // sts_sva
bind sts_sequencer sts_sva #(.COUNT_W(COUNT_W)) chk_i (.clk_sys, .rst_n, .cfg_write, .sweep_write, .cfg_in,
	.initiate_cmd, .abort_cmd, .forced_trigger_cmd, .state, .sweep_point_total, .sample_take, .err_valid, .err_code);
`default_nettype wire

// ===== dv/sts_partner.sv
// Far-side model: backplane trigger lines and front inputs
`timescale 1ns/1ps
`default_nettype none
module sts_partner (
	// Pacing pins toward the sequencer
	output var sts_pkg::sts_lines_t lines
);
	// Idle levels: ECL low, TTL and front pulled high, no bus access
	initial
	begin
		lines = '0;
		lines.ttl = 8'hFF;
		lines.front_a = 1'b1;
		lines.front_b = 1'b1;
	end
	// One line moved at a time; caller spaces pulses past the arm guard
	task automatic set(int b, logic v);
		lines[b] = v;
	endtask
endmodule // sts_partner
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                clk_sys;
	logic                rst_n;
	logic                cfg_write;
	logic                sweep_write;
	sts_pkg::sts_cfg_t   cfg_in;
	logic                initiate_cmd;
	logic                abort_cmd;
	logic                arm_event;
	logic                forced_trigger_cmd;
	logic                bus_trigger_cmd;
	logic                measure_read_query;
	sts_pkg::sts_lines_t lines;
	sts_pkg::sts_state_t state;
	logic [23:0]         sweep_point_total;
	logic [23:0]         count_limit;
	logic [7:0]          segment_count;
	logic [7:0]          burst_index;
	logic                vme_data_read;
	logic                segmented;
	logic                post_arm;
	logic                sample_take;
	logic                err_valid;
	logic [15:0]         err_code;
	int                  failures;
	int                  n_compared;
	// Device and far side
	sts_sequencer uut (.clk_sys, .rst_n, .cfg_write, .sweep_write, .cfg_in, .initiate_cmd, .abort_cmd,
		.arm_event, .forced_trigger_cmd, .bus_trigger_cmd, .measure_read_query, .lines, .state,
		.sweep_point_total, .count_limit, .segment_count, .segmented, .burst_index, .post_arm,
		.sample_take, .vme_data_read, .err_valid, .err_code);
	sts_partner p (.lines);
	// 200 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Inputs move 1 ns after the edge so sampling never races
	task automatic step(int n = 1);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic results();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		step();
		s = 1'b0;
	endtask
	// Bounded wait for a reading; a missing wanted one ends the run
	task automatic wait_sample(int n, logic want);
		int i;
		for (i = 0; i < n; i++)
		begin
			if (sample_take === 1'b1)
				break;
			step();
		end
		chk("sample_take", want, i < n);
		if (i < n)
			step();
		if (want && i >= n)
			results();
	endtask
	function automatic sts_pkg::sts_cfg_t mk(sts_pkg::sts_src_t s, logic [23:0] n, logic [7:0] a);
		sts_pkg::sts_cfg_t c;
		c = '0;
		c.src = s;
		c.count = n;
		c.arm_count = a;
		c.period1 = 32'h0000_0004;
		c.period2 = 32'h0000_0002;
		return c;
	endfunction
	task automatic wr(sts_pkg::sts_cfg_t v, logic sw);
		cfg_in = v;
		if (sw)
			pulse(sweep_write);
		else
			pulse(cfg_write);
	endtask
	task automatic go(logic arm);
		pulse(initiate_cmd);
		step();
		if (arm)
			pulse(arm_event);
	endtask
	task automatic lim(sts_pkg::sts_dest_t d, logic [7:0] a, logic neg, logic bat, logic [23:0] e, logic [7:0] sg);
		sts_pkg::sts_cfg_t c;
		c = mk(sts_pkg::STS_SRC_TIM, 24'hFF_FFFF, a);
		c.dest = d;
		c.pre_arm_neg = neg;
		c.pre_arm_points = 24'h00_0008;
		c.battery_mode = bat;
		wr(c, a[0]);
		step();
		chk("count_limit", e, count_limit);
		chk("sweep_point_total", e, sweep_point_total);
		if (neg)
			chk("segment_count", sg, segment_count);
		chk("segmented", neg && a > 1, segmented);
		$display("limit test arms %0d done", a);
	endtask
	// Wrong-direction transition first, then the active one
	task automatic t_edge(sts_pkg::sts_src_t s, logic [2:0] sel, int b, logic act);
		sts_pkg::sts_cfg_t c;
		c = mk(s, 24'h00_0001, 8'h01);
		c.ttl_sel = sel;
		p.set(b, act);
		wr(c, 1'b0);
		step(4);
		go(1'b1);
		p.set(b, !act);
		wait_sample(8, 1'b0);
		p.set(b, act);
		wait_sample(8, 1'b1);
		step(2);
		chk("state", sts_pkg::STS_IDLE, state);
		p.set(b, !act);
		step(4);
		$display("edge test line %0d done", b);
	endtask
	// Pre-arm reading, extra pulse after arm unsampled, then post-arm reading
	task automatic t_dual(sts_pkg::sts_src_t s, int pre, int post, logic act);
		wr(mk(s, 24'h00_0007, 8'h01), 1'b0);
		pulse(initiate_cmd);
		step(2);
		p.set(pre, act);
		wait_sample(8, 1'b1);
		p.set(pre, !act);
		step(4);
		pulse(arm_event);
		step(70);
		p.set(pre, act);
		wait_sample(8, 1'b0);
		chk("post_arm", 1'b1, post_arm);
		p.set(post, act);
		wait_sample(8, 1'b1);
		p.set(pre, !act);
		p.set(post, !act);
		pulse(abort_cmd);
		step(4);
		$display("dual test line %0d done", pre);
	endtask
	task automatic t_hold();
		sts_pkg::sts_cfg_t c;
		c = mk(sts_pkg::STS_SRC_HOLD, 24'h00_0001, 8'h02);
		c.pre_arm_neg = 1'b1;
		wr(c, 1'b0);
		go(1'b1);
		p.set(12, 1'b1);
		wait_sample(8, 1'b0);
		p.set(12, 1'b0);
		pulse(forced_trigger_cmd);
		wait_sample(2, 1'b1);
		step(2);
		chk("state", sts_pkg::STS_WAIT_ARM, state);
		chk("burst_index", 8'h01, burst_index);
		pulse(arm_event);
		pulse(forced_trigger_cmd);
		wait_sample(2, 1'b1);
		step(2);
		chk("state", sts_pkg::STS_IDLE, state);
		chk("burst_index", 8'h00, burst_index);
		$display("hold test done");
	endtask
	task automatic t_misc();
		int i;
		wr(mk(sts_pkg::STS_SRC_BUS, 24'h00_0001, 8'h01), 1'b0);
		go(1'b1);
		wait_sample(6, 1'b0);
		pulse(bus_trigger_cmd);
		wait_sample(4, 1'b1);
		wr(mk(sts_pkg::STS_SRC_IMM, 24'h00_0001, 8'h01), 1'b0);
		go(1'b1);
		wait_sample(4, 1'b1);
		step(2);
		wr(mk(sts_pkg::STS_SRC_TIM, 24'h00_0007, 8'h01), 1'b0);
		go(1'b1);
		wait_sample(12, 1'b1);
		for (i = 1; i < 20 && sample_take !== 1'b1; i++)
			step();
		chk("timer spacing", 4, i);
		if (i >= 20)
			results();
		pulse(abort_cmd);
		step(2);
		$display("bus, immediate and timer tests done");
	endtask
	// Timer dual rate: no reading while the guard runs, then second period paces
	task automatic t_dtim();
		int i;
		wr(mk(sts_pkg::STS_SRC_DTIM, 24'h00_0007, 8'h01), 1'b0);
		pulse(initiate_cmd);
		step(2);
		wait_sample(8, 1'b1);
		pulse(arm_event);
		wait_sample(14, 1'b0);
		wait_sample(10, 1'b1);
		chk("post_arm", 1'b1, post_arm);
		for (i = 1; i < 20 && sample_take !== 1'b1; i++)
			step();
		chk("post-arm spacing", 2, i);
		if (i >= 20)
			results();
		pulse(abort_cmd);
		step(2);
		$display("dual timer test done");
	endtask
	// Main sequence
	initial
	begin
		failures = 0;
		n_compared = 0;
		rst_n = 1'b0;
		{cfg_write, sweep_write, initiate_cmd, abort_cmd, arm_event} = '0;
		{forced_trigger_cmd, bus_trigger_cmd, measure_read_query} = '0;
		cfg_in = '0;
		step(8);
		rst_n = 1'b1;
		step();
		chk("state", sts_pkg::STS_IDLE, state);
		chk("sweep_point_total", 24'h00_0001, sweep_point_total);
		chk("count_limit", 24'h08_0000, count_limit);
		for (int n = 0; n < 8; n++)
		begin
			wr(mk(sts_pkg::STS_SRC_TIM, 24'(n), 8'h01), n[0]);
			step();
			chk("rounded count", (n >= 4) ? 24'h00_0007 : 24'h00_0001, sweep_point_total);
		end
		$display("rounding test done");
		lim(sts_pkg::STS_DEST_MEM, 8'h01, 1'b0, 1'b0, 24'h08_0000, 8'h01);
		lim(sts_pkg::STS_DEST_MEM, 8'h02, 1'b0, 1'b0, 24'h04_0000, 8'h01);
		lim(sts_pkg::STS_DEST_MEM, 8'h02, 1'b0, 1'b1, 24'h03_FFFC, 8'h01);
		lim(sts_pkg::STS_DEST_VME, 8'h01, 1'b0, 1'b0, 24'hFF_FFFF, 8'h01);
		lim(sts_pkg::STS_DEST_LOCAL, 8'h01, 1'b0, 1'b1, 24'hFF_FFFB, 8'h01);
		lim(sts_pkg::STS_DEST_MEM, 8'h03, 1'b1, 1'b0, 24'h02_0000, 8'h04);
		lim(sts_pkg::STS_DEST_MEM, 8'h05, 1'b1, 1'b0, 24'h01_0000, 8'h08);
		lim(sts_pkg::STS_DEST_MEM, 8'h80, 1'b1, 1'b1, 24'h00_0FFC, 8'h80);
		wr(mk(sts_pkg::STS_SRC_TIM, 24'h00_0007, 8'h01), 1'b0);
		go(1'b0);
		wr(mk(sts_pkg::STS_SRC_HOLD, 24'h00_0001, 8'h01), 1'b1);
		chk("sweep_point_total", 24'h00_0007, sweep_point_total);
		pulse(forced_trigger_cmd);
		chk("err_code", sts_pkg::ERR_TRIG_IGNORED, err_valid ? err_code : 16'h0000);
		pulse(abort_cmd);
		chk("state", sts_pkg::STS_IDLE, state);
		pulse(forced_trigger_cmd);
		chk("err_code", sts_pkg::ERR_TRIG_IGNORED, err_valid ? err_code : 16'h0000);
		cfg_in.count_inf = 1'b1;
		pulse(cfg_write);
		pulse(measure_read_query);
		chk("err_code", sts_pkg::ERR_TRIG_DEADLOCK, err_valid ? err_code : 16'h0000);
		$display("error tests done");
		t_hold();
		t_edge(sts_pkg::STS_SRC_ECL0, 3'h0, 12, 1'b1);
		t_edge(sts_pkg::STS_SRC_ECL1, 3'h0, 11, 1'b1);
		t_edge(sts_pkg::STS_SRC_TTL, 3'h5, 8, 1'b0);
		t_edge(sts_pkg::STS_SRC_FRA, 3'h0, 2, 1'b0);
		t_edge(sts_pkg::STS_SRC_FRB, 3'h0, 1, 1'b0);
		t_edge(sts_pkg::STS_SRC_VME, 3'h0, 0, 1'b1);
		p.set(0, 1'b1);
		step(3);
		chk("vme_data_read", 1'b1, vme_data_read);
		p.set(0, 1'b0);
		t_misc();
		t_dual(sts_pkg::STS_SRC_DECL, 12, 11, 1'b1);
		t_dual(sts_pkg::STS_SRC_DFRNT, 2, 1, 1'b0);
		t_dual(sts_pkg::STS_SRC_DTTL, 3, 4, 1'b0);
		t_dtim();
		results();
	end
endmodule // testbench
`default_nettype wire
